// File: inc/sgc_pkg.sv
// shared constants and types for the switch global control register bank
// assumes a single core clock domain and an 8-bit register access port
// Operation
// RULE1 - 8-bit registers: id 0x00-0x01, global 0x02-0x0f
// RULE2 - decode port control and status ranges per port
// RULE3 - indirect control 0x79-0x7a, data 0x7b-0x83
// RULE4 - address zero reads fixed family code, read-only
// RULE5 - address one: part code high, revision below
// RULE6 - run bit resets one; zero stops switching
// RULE7 - first control bit 7 selects alternative back-off
// RULE8 - first control bit 5 purges learned entries
// RULE9 - first control bit 4 purges fixed entries
// RULE10 - first control bit 3 forwards flow-control frames
// RULE11 - second control bit 7 forwards all frames
// RULE12 - second control bit 6 enables host trailer tagging
// RULE13 - second control bit 5 clear stops pause generation
// RULE14 - second control bit 4 clear ignores received pause
// RULE15 - second control bit 3 checks length field
// RULE16 - second control bit 2 enables address aging
// RULE17 - second control bit 1 selects fast 800us aging
// RULE18 - second control bit 0 aggressive half-duplex back-off
// RULE19 - software keeps reserved first control bits zero
// RULE20 - reserved bits and unmapped addresses read zero
`default_nettype none
package sgc_pkg;
  // ==========================================================
  // register offsets and address ranges
  localparam logic [7:0] ADDR_FAMILY      = 8'h00;
  localparam logic [7:0] ADDR_PART_REV    = 8'h01;
  localparam logic [7:0] ADDR_GCTRL_FIRST = 8'h02;
  localparam logic [7:0] ADDR_GCTRL_SEC   = 8'h03;
  localparam logic [7:0] ID_LO    = 8'h00;
  localparam logic [7:0] ID_HI    = 8'h01;
  localparam logic [7:0] GLB_LO   = 8'h02;
  localparam logic [7:0] GLB_HI   = 8'h0f;
  localparam logic [7:0] P1C_LO   = 8'h10;
  localparam logic [7:0] P1C_HI   = 8'h1d;
  localparam logic [7:0] P1S_LO   = 8'h1e;
  localparam logic [7:0] P1S_HI   = 8'h1f;
  localparam logic [7:0] P2C_LO   = 8'h20;
  localparam logic [7:0] P2C_HI   = 8'h2d;
  localparam logic [7:0] P2S_LO   = 8'h2e;
  localparam logic [7:0] P2S_HI   = 8'h2f;
  localparam logic [7:0] P3C_LO   = 8'h30;
  localparam logic [7:0] P3C_HI   = 8'h39;
  localparam logic [7:0] P3S_ADDR = 8'h3f;
  localparam logic [7:0] INC_LO   = 8'h79;
  localparam logic [7:0] INC_HI   = 8'h7a;
  localparam logic [7:0] IND_LO   = 8'h7b;
  localparam logic [7:0] IND_HI   = 8'h83;
  // ==========================================================
  // field positions
  localparam int RUN_BIT      = 0;
  localparam int REV_LSB      = 1;
  localparam int PART_LSB     = 4;
  localparam int ALT_BO_BIT   = 7;
  localparam int LRN_PRG_BIT  = 5;
  localparam int FIX_PRG_BIT  = 4;
  localparam int PASS_FC_BIT  = 3;
  localparam int PASS_ALL_BIT = 7;
  localparam int TRAIL_BIT    = 6;
  localparam int TX_PAU_BIT   = 5;
  localparam int RX_PAU_BIT   = 4;
  localparam int LEN_CHK_BIT  = 3;
  localparam int AGE_EN_BIT   = 2;
  localparam int FAST_AGE_BIT = 1;
  localparam int AGGR_BO_BIT  = 0;
  // ==========================================================
  // reset values and write masks
  localparam logic       RUN_RST        = 1'b1;
  localparam logic [7:0] GC_FIRST_RST   = 8'h00;
  localparam logic [7:0] GC_FIRST_WMASK = 8'hb8;
  localparam logic [7:0] GC_SEC_RST     = 8'h34;
  // ==========================================================
  // fast aging period
  localparam int         CLK_MHZ     = 125;
  localparam int         FAST_AGE_US = 800;
  localparam int         AGE_CNT_W   = 17;
  localparam logic [AGE_CNT_W-1:0] FAST_AGE_CYCLES_DEF =
    AGE_CNT_W'(FAST_AGE_US * CLK_MHZ);
  // ==========================================================
  // types
  typedef enum logic [10:0] {
    REG_NONE  = 11'h001, REG_ID    = 11'h002, REG_GLB   = 11'h004,
    REG_P1C   = 11'h008, REG_P1S   = 11'h010, REG_P2C   = 11'h020,
    REG_P2S   = 11'h040, REG_P3C   = 11'h080, REG_P3S   = 11'h100,
    REG_INDC  = 11'h200, REG_INDD  = 11'h400
  } sgc_region_t;
  typedef struct packed {
    logic switchRun;
    logic altBackoff;
    logic learnedEntryPurge;
    logic fixedEntryPurge;
    logic passFlowCtrl;
    logic passAllFrames;
    logic hostTrailerTag;
    logic txPauseEn;
    logic rxPauseEn;
    logic lenFieldCheck;
    logic agingEn;
    logic fastAgeEn;
    logic aggrBackoff;
  } sgc_ctrl_t;
  typedef struct packed {
    logic                 run;
    logic [7:0]           gcFirst;
    logic [7:0]           gcSec;
    logic [7:0]           rdata;
    logic                 ack;
    sgc_region_t          region;
    logic [AGE_CNT_W-1:0] ageCnt;
    logic                 ageTick;
  } sgc_state_t;
endpackage
`default_nettype wire

// File: design/sgc_regs.sv
// global register bank: identification, run control, two control bytes
// assumes the serial management decoder on core_clk drives the access port
`default_nettype none
module sgc_regs #(
  parameter logic [7:0] FAMILY_CODE      = 8'h5a, // arbitrary value
  parameter logic [3:0] PART_CODE        = 4'h9,  // arbitrary value
  parameter logic [2:0] SILICON_REV_CODE = 3'h2,  // arbitrary value
  parameter logic [sgc_pkg::AGE_CNT_W-1:0] FAST_AGE_CYCLES =
    sgc_pkg::FAST_AGE_CYCLES_DEF
) (
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  input  wire logic          regReq,
  input  wire logic          regWrite,
  input  wire logic [7:0]    regAddr,
  input  wire logic [7:0]    regWdata,
  output logic               regAck,
  output logic [7:0]         regRdata,
  output sgc_pkg::sgc_region_t regRegion,
  output sgc_pkg::sgc_ctrl_t ctrl,
  output logic               fastAgeTick
);

  // ==========================================================
  // address map decode
  function automatic logic inRange(input logic [7:0] a,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // one region per address across the whole space
  function automatic sgc_pkg::sgc_region_t decodeRegion(
      input logic [7:0] a);
    if (inRange(a, sgc_pkg::ID_LO, sgc_pkg::ID_HI)) begin // see RULE1
      decodeRegion = sgc_pkg::REG_ID;
    end else if (inRange(a, sgc_pkg::GLB_LO, sgc_pkg::GLB_HI)) begin
      decodeRegion = sgc_pkg::REG_GLB; // see RULE1
    end else if (inRange(a, sgc_pkg::P1C_LO, sgc_pkg::P1C_HI)) begin
      decodeRegion = sgc_pkg::REG_P1C; // see RULE2
    end else if (inRange(a, sgc_pkg::P1S_LO, sgc_pkg::P1S_HI)) begin
      decodeRegion = sgc_pkg::REG_P1S; // see RULE2
    end else if (inRange(a, sgc_pkg::P2C_LO, sgc_pkg::P2C_HI)) begin
      decodeRegion = sgc_pkg::REG_P2C; // see RULE2
    end else if (inRange(a, sgc_pkg::P2S_LO, sgc_pkg::P2S_HI)) begin
      decodeRegion = sgc_pkg::REG_P2S; // see RULE2
    end else if (inRange(a, sgc_pkg::P3C_LO, sgc_pkg::P3C_HI)) begin
      decodeRegion = sgc_pkg::REG_P3C; // see RULE2
    end else if (a == sgc_pkg::P3S_ADDR) begin
      decodeRegion = sgc_pkg::REG_P3S; // see RULE2
    end else if (inRange(a, sgc_pkg::INC_LO, sgc_pkg::INC_HI)) begin
      decodeRegion = sgc_pkg::REG_INDC; // see RULE3
    end else if (inRange(a, sgc_pkg::IND_LO, sgc_pkg::IND_HI)) begin
      decodeRegion = sgc_pkg::REG_INDD; // see RULE3
    end else begin
      decodeRegion = sgc_pkg::REG_NONE;
    end
  endfunction

  // ==========================================================
  // state
  sgc_pkg::sgc_state_t state_reg;
  sgc_pkg::sgc_state_t state_next;
  logic [7:0]          readValue;
  logic                ageActive;
  logic [7:0]          gcF;
  logic [7:0]          gcS;

  // read mux over the locally held registers
  always_comb begin
    unique case (regAddr)
      sgc_pkg::ADDR_FAMILY: begin
        readValue = FAMILY_CODE; // see RULE4
      end
      sgc_pkg::ADDR_PART_REV: begin
        readValue = {PART_CODE, SILICON_REV_CODE, state_reg.run}; // see RULE5
      end
      sgc_pkg::ADDR_GCTRL_FIRST: begin
        readValue = state_reg.gcFirst; // see RULE20
      end
      sgc_pkg::ADDR_GCTRL_SEC: begin
        readValue = state_reg.gcSec;
      end
      default: begin
        readValue = 8'h00; // see RULE20
      end
    endcase
  end

  assign ageActive = state_reg.gcSec[sgc_pkg::AGE_EN_BIT] &&
                     state_reg.gcSec[sgc_pkg::FAST_AGE_BIT];

  // next state: access port, writes, fast aging timer
  always_comb begin
    state_next         = state_reg;
    state_next.ack     = 1'b0;
    state_next.ageTick = 1'b0;
    if (regReq) begin
      state_next.ack    = 1'b1;
      state_next.rdata  = readValue;
      state_next.region = decodeRegion(regAddr);
      if (regWrite) begin
        unique case (regAddr)
          sgc_pkg::ADDR_PART_REV: begin
            state_next.run = regWdata[sgc_pkg::RUN_BIT]; // see RULE6
          end
          sgc_pkg::ADDR_GCTRL_FIRST: begin
            // reserved bits stay zero whatever is written, see RULE20
            state_next.gcFirst = regWdata & sgc_pkg::GC_FIRST_WMASK;
          end
          sgc_pkg::ADDR_GCTRL_SEC: begin
            state_next.gcSec = regWdata; // see RULE11
          end
          default: begin
            state_next.run = state_reg.run; // see RULE4
          end
        endcase
      end
    end
    // fast aging tick only while both aging bits are set
    if (ageActive) begin // see RULE16
      if (state_reg.ageCnt >= FAST_AGE_CYCLES - 1'b1) begin // see RULE17
        state_next.ageCnt  = '0;
        state_next.ageTick = 1'b1;
      end else begin
        state_next.ageCnt = state_reg.ageCnt + 1'b1;
      end
    end else begin
      state_next.ageCnt = '0;
    end
  end

  // register the whole state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.run     <= sgc_pkg::RUN_RST;
      state_reg.gcFirst <= sgc_pkg::GC_FIRST_RST;
      state_reg.gcSec   <= sgc_pkg::GC_SEC_RST;
      state_reg.rdata   <= 8'h00;
      state_reg.ack     <= 1'b0;
      state_reg.region  <= sgc_pkg::REG_NONE;
      state_reg.ageCnt  <= '0;
      state_reg.ageTick <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign regAck      = state_reg.ack;
  assign regRdata    = state_reg.rdata;
  assign regRegion   = state_reg.region;
  assign fastAgeTick = state_reg.ageTick;

  // short views of the two control bytes
  assign gcF = state_reg.gcFirst;
  assign gcS = state_reg.gcSec;

  // control levels to the switch engine
  always_comb begin
    ctrl.switchRun         = state_reg.run; // see RULE6
    ctrl.altBackoff        = gcF[sgc_pkg::ALT_BO_BIT]; // see RULE7
    ctrl.learnedEntryPurge = gcF[sgc_pkg::LRN_PRG_BIT]; // see RULE8
    ctrl.fixedEntryPurge   = gcF[sgc_pkg::FIX_PRG_BIT]; // see RULE9
    ctrl.passFlowCtrl      = gcF[sgc_pkg::PASS_FC_BIT]; // see RULE10
    ctrl.passAllFrames     = gcS[sgc_pkg::PASS_ALL_BIT]; // see RULE11
    ctrl.hostTrailerTag    = gcS[sgc_pkg::TRAIL_BIT]; // see RULE12
    ctrl.txPauseEn         = gcS[sgc_pkg::TX_PAU_BIT]; // see RULE13
    ctrl.rxPauseEn         = gcS[sgc_pkg::RX_PAU_BIT]; // see RULE14
    ctrl.lenFieldCheck     = gcS[sgc_pkg::LEN_CHK_BIT]; // see RULE15
    ctrl.agingEn           = gcS[sgc_pkg::AGE_EN_BIT]; // see RULE16
    ctrl.fastAgeEn         = gcS[sgc_pkg::FAST_AGE_BIT]; // see RULE17
    ctrl.aggrBackoff       = gcS[sgc_pkg::AGGR_BO_BIT]; // see RULE18
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_ack_follows_req: assert property ( // see RULE1
    regReq |=> regAck ##1 (!regAck || $past(regReq)))
    else $error("ack did not follow request");

  a_ack_idle: assert property ( // see RULE1
    !regReq |=> !regAck)
    else $error("ack without request");

  a_region_port1: assert property ( // see RULE2
    regReq && regAddr >= 8'h10 && regAddr <= 8'h1d
      |=> regRegion == sgc_pkg::REG_P1C)
    else $error("port one control range misdecoded");

  a_region_host: assert property ( // see RULE2
    regReq && (regAddr == 8'h3f || regAddr == 8'h3a)
      |=> regRegion == ($past(regAddr) == 8'h3f ?
                        sgc_pkg::REG_P3S : sgc_pkg::REG_NONE))
    else $error("host port status misdecoded");

  a_region_indirect: assert property ( // see RULE3
    regReq && regAddr >= 8'h79 && regAddr <= 8'h83
      |=> regRegion inside {sgc_pkg::REG_INDC, sgc_pkg::REG_INDD})
    else $error("indirect range misdecoded");

  a_region_id: assert property ( // see RULE1
    regReq && regAddr <= 8'h01 |=> regRegion == sgc_pkg::REG_ID)
    else $error("identification range misdecoded");

  a_region_global: assert property ( // see RULE1
    regReq && regAddr >= 8'h02 && regAddr <= 8'h0f
      |=> regRegion == sgc_pkg::REG_GLB)
    else $error("global control range misdecoded");

  a_region_port2: assert property ( // see RULE2
    regReq && regAddr >= 8'h20 && regAddr <= 8'h2d
      |=> regRegion == sgc_pkg::REG_P2C)
    else $error("port two control range misdecoded");

  a_region_status: assert property ( // see RULE2
    regReq && regAddr inside {8'h1e, 8'h1f, 8'h2e, 8'h2f}
      |=> regRegion == ($past(regAddr[5]) ? sgc_pkg::REG_P2S
                                           : sgc_pkg::REG_P1S))
    else $error("port status range misdecoded");

  a_region_host_ctrl: assert property ( // see RULE2
    regReq && regAddr >= 8'h30 && regAddr <= 8'h39
      |=> regRegion == sgc_pkg::REG_P3C)
    else $error("host port control range misdecoded");

  a_family_read: assert property ( // see RULE4
    regReq && !regWrite && regAddr == 8'h00 |=> regRdata == FAMILY_CODE)
    else $error("family code read wrong");

  a_part_rev_read: assert property ( // see RULE5
    regReq && regAddr == 8'h01
      |=> regRdata[7:1] == {PART_CODE, SILICON_REV_CODE})
    else $error("part or revision code read wrong");

  a_run_write: assert property ( // see RULE6
    regReq && regWrite && regAddr == 8'h01
      |=> ctrl.switchRun == $past(regWdata[0]))
    else $error("run bit not written");

  a_run_hold: assert property ( // see RULE6
    !(regReq && regWrite && regAddr == 8'h01) |=> $stable(ctrl.switchRun))
    else $error("run bit changed without write");

  a_run_read: assert property ( // see RULE6
    regReq && !regWrite && regAddr == 8'h01
      |=> regRdata[0] == ctrl.switchRun)
    else $error("run bit read back wrong");

  a_first_write: assert property ( // see RULE7
    regReq && regWrite && regAddr == 8'h02
      |=> {ctrl.altBackoff, ctrl.learnedEntryPurge, ctrl.fixedEntryPurge,
           ctrl.passFlowCtrl} == {$past(regWdata[7]), $past(regWdata[5]),
                                  $past(regWdata[4]), $past(regWdata[3])})
    else $error("first control byte not applied");

  a_first_rsvd: assert property ( // see RULE20
    regReq && !regWrite && regAddr == 8'h02
      |=> regRdata[6] == 1'b0 && regRdata[2:0] == 3'h0)
    else $error("reserved bits read nonzero");

  a_second_write: assert property ( // see RULE13
    regReq && regWrite && regAddr == 8'h03
      |=> ctrl.txPauseEn == $past(regWdata[5]) &&
          ctrl.rxPauseEn == $past(regWdata[4]) &&
          ctrl.passAllFrames == $past(regWdata[7]))
    else $error("second control byte not applied");

  a_second_rest: assert property ( // see RULE12
    regReq && regWrite && regAddr == 8'h03
      |=> ctrl.hostTrailerTag == $past(regWdata[6]) &&
          ctrl.lenFieldCheck == $past(regWdata[3]) &&
          ctrl.aggrBackoff == $past(regWdata[0]))
    else $error("tag, length or back-off bit not applied");

  a_aging_write: assert property ( // see RULE16
    regReq && regWrite && regAddr == 8'h03
      |=> ctrl.agingEn == $past(regWdata[2]) &&
          ctrl.fastAgeEn == $past(regWdata[1]))
    else $error("aging bits not applied");

  a_ctrl_hold: assert property ( // see RULE20
    !(regReq && regWrite && regAddr inside {8'h01, 8'h02, 8'h03})
      |=> $stable(ctrl))
    else $error("control levels changed without write");

  a_first_rsvd_wr: assert property ( // see RULE20
    regReq && regWrite && regAddr == 8'h02
      |=> (gcF & ~sgc_pkg::GC_FIRST_WMASK) == 8'h00)
    else $error("reserved control bits took a write");

  a_unmapped_zero: assert property ( // see RULE20
    regReq && !regWrite && regAddr > 8'h03 |=> regRdata == 8'h00)
    else $error("unmapped read nonzero");

  a_age_off: assert property ( // see RULE16
    !(ctrl.agingEn && ctrl.fastAgeEn) |=> !fastAgeTick)
    else $error("aging tick while aging off");

  a_age_gap: assert property ( // see RULE17
    fastAgeTick |=> !fastAgeTick)
    else $error("fast aging ticks back to back");

  c_stop_switch: cover property (
    regReq && regWrite && regAddr == 8'h01 && !regWdata[0]);
  c_second_write: cover property (regReq && regWrite && regAddr == 8'h03);
  c_fast_tick: cover property (fastAgeTick);
  c_purge_both: cover property (ctrl.learnedEntryPurge && ctrl.fixedEntryPurge);
  c_indirect_read: cover property (regAck && regRegion == sgc_pkg::REG_INDD);

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the global control register bank
// assumes sgc_pkg is compiled first; design assertions sit in the design
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // identity values handed to the design, all arbitrary, and a shortened aging period
  localparam logic [7:0] FAM  = 8'hc3; // arbitrary value
  localparam logic [3:0] PART = 4'h6;  // arbitrary value
  localparam logic [2:0] REV  = 3'h5;  // arbitrary value
  localparam int         AGE  = 8;     // shortened fast aging period
  typedef struct packed {
    logic                 wr;
    logic [7:0]           addr;
    logic [7:0]           wdata;
    sgc_pkg::sgc_region_t rg;
  } sgc_row_t;
  logic                 core_clk = 1'b0;
  logic                 rst_b    = 1'b0;
  logic                 regReq   = 1'b0;
  logic                 regWrite = 1'b0;
  logic [7:0]           regAddr  = 8'h00;
  logic [7:0]           regWdata = 8'h00;
  logic                 regAck;
  logic [7:0]           regRdata;
  sgc_pkg::sgc_region_t regRegion;
  sgc_pkg::sgc_ctrl_t   ctrl;
  logic                 fastAgeTick;
  int                   fails      = 0;
  int                   num_checks = 0;
  logic                 runM = 1'b1;
  logic [7:0]           gfM  = 8'h00;
  logic [7:0]           gsM  = 8'h34;
  int                   n;
  // ==========================================================
  // ordinary accesses: inputs beside the expected region
  sgc_row_t rows [32] = '{
    '{1'b0, 8'h00, 8'h00, sgc_pkg::REG_ID}, '{1'b1, 8'h00, 8'hff, sgc_pkg::REG_ID},
    '{1'b0, 8'h00, 8'h00, sgc_pkg::REG_ID}, '{1'b0, 8'h01, 8'h00, sgc_pkg::REG_ID},
    '{1'b1, 8'h01, 8'hfe, sgc_pkg::REG_ID}, '{1'b0, 8'h01, 8'h00, sgc_pkg::REG_ID},
    '{1'b1, 8'h01, 8'h01, sgc_pkg::REG_ID}, '{1'b1, 8'h02, 8'hff, sgc_pkg::REG_GLB},
    '{1'b0, 8'h02, 8'h00, sgc_pkg::REG_GLB}, '{1'b1, 8'h03, 8'hcb, sgc_pkg::REG_GLB},
    '{1'b0, 8'h03, 8'h00, sgc_pkg::REG_GLB}, '{1'b1, 8'h03, 8'h30, sgc_pkg::REG_GLB},
    '{1'b0, 8'h03, 8'h00, sgc_pkg::REG_GLB}, '{1'b1, 8'h02, 8'h00, sgc_pkg::REG_GLB},
    '{1'b1, 8'h04, 8'hff, sgc_pkg::REG_GLB}, '{1'b0, 8'h04, 8'h00, sgc_pkg::REG_GLB},
    '{1'b0, 8'h0f, 8'h00, sgc_pkg::REG_GLB}, '{1'b0, 8'h10, 8'h00, sgc_pkg::REG_P1C},
    '{1'b0, 8'h1d, 8'h00, sgc_pkg::REG_P1C}, '{1'b0, 8'h1e, 8'h00, sgc_pkg::REG_P1S},
    '{1'b0, 8'h20, 8'h00, sgc_pkg::REG_P2C}, '{1'b0, 8'h2f, 8'h00, sgc_pkg::REG_P2S},
    '{1'b0, 8'h30, 8'h00, sgc_pkg::REG_P3C}, '{1'b0, 8'h39, 8'h00, sgc_pkg::REG_P3C},
    '{1'b0, 8'h3a, 8'h00, sgc_pkg::REG_NONE}, '{1'b0, 8'h3f, 8'h00, sgc_pkg::REG_P3S},
    '{1'b0, 8'h79, 8'h00, sgc_pkg::REG_INDC}, '{1'b0, 8'h7a, 8'h00, sgc_pkg::REG_INDC},
    '{1'b0, 8'h7b, 8'h00, sgc_pkg::REG_INDD}, '{1'b0, 8'h83, 8'h00, sgc_pkg::REG_INDD},
    '{1'b0, 8'h84, 8'h00, sgc_pkg::REG_NONE}, '{1'b0, 8'hff, 8'h00, sgc_pkg::REG_NONE}};

  // clock, 8 ns period
  always #4 core_clk = ~core_clk;

  sgc_regs #(
    .FAMILY_CODE      (FAM),
    .PART_CODE        (PART),
    .SILICON_REV_CODE (REV),
    .FAST_AGE_CYCLES  (sgc_pkg::AGE_CNT_W'(AGE))
  ) dut (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .regReq      (regReq),
    .regWrite    (regWrite),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regAck      (regAck),
    .regRdata    (regRdata),
    .regRegion   (regRegion),
    .ctrl        (ctrl),
    .fastAgeTick (fastAgeTick)
  );

  // ==========================================================
  // compare tasks, one per kind of result
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkc(input sgc_pkg::sgc_ctrl_t e, input sgc_pkg::sgc_ctrl_t g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD ctrl expected %h seen %h", e, g);
    end
  endtask
  task automatic chkr(input sgc_pkg::sgc_region_t e, input sgc_pkg::sgc_region_t g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD region expected %h seen %h", e, g);
    end
  endtask

  // ==========================================================
  // register model
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return FAM;
      8'h01: return {PART, REV, runM};
      8'h02: return gfM;
      8'h03: return gsM;
      default: return 8'h00;
    endcase
  endfunction
  function automatic sgc_pkg::sgc_ctrl_t exp_ctrl();
    return {runM, gfM[7], gfM[5], gfM[4], gfM[3], gsM};
  endfunction
  function automatic void upd(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h01) runM = d[0];
    if (a == 8'h02) gfM = d & 8'hb8;
    if (a == 8'h03) gsM = d;
  endfunction

  // one access: request one cycle, check answer the cycle after
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = exp_rd(a);
    @(posedge core_clk);
    regReq   <= 1'b1;
    regWrite <= wr;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regReq <= 1'b0;
    if (wr) upd(a, d);
    #1;
    chk1("ack", 1'b1, regAck);
    chk8("rdata", e, regRdata);
    chkc(exp_ctrl(), ctrl);
  endtask

  // reset for four cycles, checked while held
  task automatic do_reset();
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    runM = 1'b1;
    gfM  = 8'h00;
    gsM  = 8'h34;
    #1;
    chkc(exp_ctrl(), ctrl);
    chk1("ack", 1'b0, regAck);
    chkr(sgc_pkg::REG_NONE, regRegion);
    chk8("reset rdata", 8'h00, regRdata);
    chk1("reset tick", 1'b0, fastAgeTick);
    @(posedge core_clk);
    rst_b <= 1'b1;
    $display("test reset done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    foreach (rows[i]) begin
      acc(rows[i].wr, rows[i].addr, rows[i].wdata);
      chkr(rows[i].rg, regRegion);
    end
    $display("test table done");
    // back-to-back write then read of the first control byte
    @(posedge core_clk);
    regReq   <= 1'b1;
    regWrite <= 1'b1;
    regAddr  <= 8'h02;
    regWdata <= 8'h28;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
    chk1("ack", 1'b1, regAck);
    chk8("old first", 8'h00, regRdata);
    @(posedge core_clk);
    regReq <= 1'b0;
    upd(8'h02, 8'h28);
    #1;
    chk1("ack", 1'b1, regAck);
    chk8("new first", 8'h28, regRdata);
    chkc(exp_ctrl(), ctrl);
    $display("test back_to_back done");
    // fast aging: period, then silence once fast aging is off
    acc(1'b1, 8'h03, 8'h06);
    n = 0;
    while (fastAgeTick !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk1("first tick", 1'b1, fastAgeTick);
    chk8("first delay", 8'(AGE), 8'(n));
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (fastAgeTick !== 1'b1 && n < 40);
    chk8("tick period", 8'(AGE), 8'(n));
    acc(1'b1, 8'h03, 8'h04);
    n = 0;
    repeat (3 * AGE) begin
      @(posedge core_clk);
      #1;
      if (fastAgeTick !== 1'b0) n++;
    end
    chk8("ticks when slow", 8'h00, 8'(n));
    $display("test aging done");
    // reset in mid-run restores defaults
    acc(1'b1, 8'h01, 8'h00);
    do_reset();
    acc(1'b0, 8'h01, 8'h00);
    acc(1'b0, 8'h03, 8'h00);
    $display("test mid_reset done");
    print_verdict();
  end

  // watchdog, well past the expected 130 or so cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
